// File: asp_ctrl.v
// Serial transfer and power-mode control of a four-channel converter
//
// Decided for this implementation: the register offsets and the strobed register port.
`timescale 1ns/1ps
`include "asp_defs.vh"

module asp_ctrl (
  input wire ref_clk_i,
  input wire nrst_i,
  // Serial pins from the host
  input wire cs_n_i,
  input wire sclk_i,
  input wire sdi_i,
  // Three-state serial output: enable is low while driving
  output reg sdo_o,
  output reg sdo_oe_n_o,
  // Analog-side controls
  output wire track_o,
  output wire powered_o,
  output wire ready_o,
  output wire [1:0] chan_tag_o,
  output wire range_o,
  output wire coding_o,
  // Register port
  input wire [`ASP_ADDR_W-1:0] reg_addr_i,
  input wire [`ASP_DATA_W-1:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output reg [`ASP_DATA_W-1:0] reg_rdata_o
);
  // Wake-up time in system clock cycles, rounded up, at least one
  // Rounding up means a changed clock rate can only lengthen the wait, while WAKE_CYC fits the 7-bit counter
  localparam integer WAKE_RAW =
    (`ASP_WAKE_NS * `ASP_CLK_KHZ + 999999) / 1000000;
  localparam integer WAKE_CYC = (WAKE_RAW < 1) ? 1 : WAKE_RAW;

  // Reset release chain
  reg rst_s1_q;
  reg rst_n_q;

  // Synchronised pin levels and edges
  wire [2:0] pin_lvl;
  wire [2:0] pin_rise;
  wire [2:0] pin_fall;
  wire cs_fall;
  wire cs_rise;
  wire sclk_fall;
  wire din_lvl;

  // Transfer state
  reg in_frame_q;             // Chip select low and frame not aborted
  reg [4:0] edge_cnt_q;       // Falling serial clock edges seen so far
  reg [14:0] out_sh_q;        // Remaining output bits after the one shown
  reg [`ASP_CTRL_W-1:0] in_sh_q; // Incoming control word
  reg complete_q;             // Sixteen edges reached in this frame
  reg mute_q;                 // Output kept undriven for this frame

  // Control and power state
  reg [`ASP_CTRL_W-1:0] ctrl_q;  // Live control register
  reg powered_q;              // Internal circuitry powered
  reg track_q;                // Track-and-hold tracking when high
  reg [6:0] wake_cnt_q;       // Counts down the wake-up time
  reg abort_q;                // Sticky: a frame ended early

  // Software-supplied conversion result
  reg [11:0] result_q;

  // Current power-select pair, decoded from the live control register
  wire [1:0] pm;
  // Status word as seen by software; layout is given at its assembly
  wire [`ASP_DATA_W-1:0] status;

  // Extract the power-select pair from a control word
  function [1:0] pm_of;
    input [`ASP_CTRL_W-1:0] word;
    begin
      pm_of = {word[`ASP_F_PSEL_HI], word[`ASP_F_PSEL_LO]};
    end
  endfunction

  // Full-shutdown code test; a frame started in this mode stays undriven
  function is_full_sd;
    input [1:0] mode;
    begin
      is_full_sd = (mode == `ASP_PM_FULL_SD);
    end
  endfunction

  // Mode in force after a complete frame: only a write can move it, so a
  // read-only frame leaves the power mode as it was
  function [1:0] pm_next;
    input [`ASP_CTRL_W-1:0] word;
    input [1:0] cur;
    begin
      if (word[`ASP_F_WRITE]) begin
        pm_next = pm_of(word);
      end else begin
        pm_next = cur;
      end
    end
  endfunction

  // Release reset through two flip-flops
  // Assertion stays asynchronous; only the release is retimed, so no
  // flop leaves reset on a different edge from its neighbours
  always @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_s1_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q <= rst_s1_q;
    end
  end

  // All three host pins cross into the system clock here. Every pin
  // event is seen about four system clocks late, all three alike, so
  // edges keep their order. The price: each serial clock phase must last
  // at least two system clocks, which caps the serial clock well below
  // the system clock rate; a faster host clock would lose edges.
  asp_pin_sync u_sync (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_q),
    .pin_i({sdi_i, sclk_i, cs_n_i}),
    .level_o(pin_lvl),
    .rise_o(pin_rise),
    .fall_o(pin_fall)
  );

  // Bit 0 is chip select, bit 1 the serial clock, bit 2 the data input
  assign cs_fall = pin_fall[0];
  assign cs_rise = pin_rise[0];
  // Edges only count inside a live frame, never while deselected
  assign sclk_fall = pin_fall[1] & in_frame_q & ~pin_lvl[0];
  assign din_lvl = pin_lvl[2];
  assign pm = pm_of(ctrl_q);

  // A frame is a select fall, up to sixteen counted serial clock falls
  // and a select rise; everything happens on system clock edges.
  // Frame sequencing runs on the system clock, stepping on synchronised
  // host serial clock falls; the pace follows that clock about four system clocks late
  always @(posedge ref_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      // Out of reset the pad is released and no frame is open
      in_frame_q <= 1'b0;
      edge_cnt_q <= 5'd0;
      out_sh_q <= 15'h0000;
      in_sh_q <= `ASP_CTRL_RST;
      complete_q <= 1'b0;
      mute_q <= 1'b1;
      sdo_o <= 1'b0;
      sdo_oe_n_o <= 1'b1;
    end else if (cs_fall) begin
      // New frame: load the word, show the first leading zero
      in_frame_q <= 1'b1;
      edge_cnt_q <= 5'd0;
      complete_q <= 1'b0;
      // Two zeros, channel tag high bit first, then result
      out_sh_q <= {1'b0, ctrl_q[`ASP_F_CHAN_HI], ctrl_q[`ASP_F_CHAN_LO],
                   result_q};
      sdo_o <= 1'b0;
      // A wake transfer out of full shutdown never drives
      mute_q <= is_full_sd(pm);
      // Otherwise the pad leaves high impedance with the first zero
      sdo_oe_n_o <= is_full_sd(pm);
    end else if (cs_rise) begin
      // End of frame, complete or not: release the output
      in_frame_q <= 1'b0;
      sdo_oe_n_o <= 1'b1;
      // The abort itself is noted by the register process below
    end else if (sclk_fall && !complete_q) begin
      // Edges past the sixteenth wait for the next select fall
      edge_cnt_q <= edge_cnt_q + 5'd1;
      // Serial input is taken over the first twelve edges
      if (edge_cnt_q < `ASP_CTRL_EDGES) begin
        in_sh_q <= {in_sh_q[`ASP_CTRL_W-2:0], din_lvl};
      end
      // Launch next bit on edges one through fifteen
      if (edge_cnt_q < `ASP_LAST_LAUNCH - 5'd1 + 5'd1) begin
        // A muted frame keeps the pad line still rather than toggling it
        // behind a disabled driver, which saves needless switching
        sdo_o <= mute_q ? 1'b0 : out_sh_q[14];
        out_sh_q <= {out_sh_q[13:0], 1'b0};
      end
      // Sixteenth edge: frame complete, output released
      if (edge_cnt_q == `ASP_FRAME_LEN - 5'd1) begin
        complete_q <= 1'b1;
        sdo_oe_n_o <= 1'b1;
        mute_q <= 1'b1;
      end
    end
  end

  // Power mode, track-and-hold and control register update
  always @(posedge ref_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ctrl_q <= `ASP_CTRL_RST;
      powered_q <= 1'b0;
      track_q <= 1'b0;
    end else if (cs_fall) begin
      // A select fall while in full shutdown leaves it asleep: only a write
      // of a new mode, at the end of the frame, can wake it
      if (!powered_q && pm == `ASP_PM_AUTO_SD) begin
        // Auto sleep ends: power up and resume tracking
        powered_q <= 1'b1;
        track_q <= 1'b1;
      end else begin
        // Sample: track-and-hold goes to hold
        track_q <= 1'b0;
      end
    end else if (cs_rise && in_frame_q) begin
      if (complete_q) begin
        // Only a full frame with write bit set updates control
        if (in_sh_q[`ASP_F_WRITE]) begin
          ctrl_q <= in_sh_q;
        end
        // Mode seen after this frame; write bit low keeps it
        case (pm_next(in_sh_q, pm))
          `ASP_PM_NORMAL: begin
            // Both bits set keeps or brings full power
            powered_q <= 1'b1;
            // The fourteenth edge has passed, so the input tracks now even
            // when this frame woke the part out of a shutdown
            track_q <= 1'b1;
          end
          `ASP_PM_FULL_SD: begin
            // Full shutdown on this chip select rise
            powered_q <= 1'b0;
            track_q <= 1'b0;
          end
          `ASP_PM_AUTO_SD: begin
            // Sleep only now, at the end of the conversion
            powered_q <= 1'b0;
            track_q <= 1'b0;
          end
          default: begin
            // Unused code, seen after reset or after a write of both bits clear: behave as normal
            powered_q <= 1'b1;
            track_q <= 1'b1;
          end
        endcase
      end else if (!powered_q) begin
        // Aborted frame while shut down keeps hold
        track_q <= 1'b0;
      end else begin
        // Aborted frame: conversion dropped, input tracks again
        track_q <= 1'b1;
      end
    end else if (sclk_fall && !complete_q &&
                 edge_cnt_q == `ASP_TRACK_EDGE - 5'd1) begin
      // Fourteenth edge returns to tracking if powered
      track_q <= powered_q;
    end
  end

  // Wake-up timer: ready only after the wake time while powered
  // The count runs on the system clock, not the serial clock, so the
  // wait is a true time whatever rate the host picks
  always @(posedge ref_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      wake_cnt_q <= 7'd0;
    end else if (!powered_q) begin
      // Reload so a fresh wake always waits the full time
      wake_cnt_q <= WAKE_CYC[6:0];
    end else if (wake_cnt_q != 7'd0) begin
      wake_cnt_q <= wake_cnt_q - 7'd1;
    end
  end

  // Register writes and the sticky abort flag
  // Only the result register is writable; control moves only over the
  // serial link, so software cannot disturb a frame in flight
  always @(posedge ref_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      result_q <= 12'h000;
      abort_q <= 1'b0;
    end else begin
      if (reg_wr_i && reg_addr_i == `ASP_REG_RESULT) begin
        result_q <= reg_wdata_i[11:0];
      end
      // An abort in the same cycle as the read-clear is kept: losing it
      // would hide a cut frame, while a second read costs nothing
      if (cs_rise && in_frame_q && !complete_q) begin
        abort_q <= 1'b1;
      end else if (reg_rd_i && reg_addr_i == `ASP_REG_STATUS) begin
        abort_q <= 1'b0;
      end
    end
  end

  // Status word assembled from live state, low bit first:
  //   0 powered, 1 ready, 2 tracking, 3 frame open,
  //   4 low power bit, 5 high power bit, 6 pad driven,
  //   7 early select rise seen (cleared by reading status)
  // The upper byte reads as zero and is kept free for growth
  assign status = {8'h00, abort_q, ~sdo_oe_n_o, pm[1], pm[0],
                   in_frame_q, track_q, ready_o, powered_q};

  // Read data one cycle after the strobe; unmapped reads give zero
  // Data falls back to zero after one cycle so a stale word is never
  // mistaken for a fresh answer
  always @(posedge ref_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      reg_rdata_o <= 16'h0000;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        `ASP_REG_CTRL: reg_rdata_o <= {4'h0, ctrl_q};
        `ASP_REG_STATUS: reg_rdata_o <= status;
        `ASP_REG_RESULT: reg_rdata_o <= {4'h0, result_q};
        default: reg_rdata_o <= 16'h0000;
      endcase
    end else begin
      reg_rdata_o <= 16'h0000;
    end
  end

  // Outputs follow their flip-flops directly; ready is the one decode
  assign track_o = track_q;
  assign powered_o = powered_q;
  assign ready_o = powered_q & (wake_cnt_q == 7'd0);
  assign chan_tag_o = {ctrl_q[`ASP_F_CHAN_HI], ctrl_q[`ASP_F_CHAN_LO]};
  assign range_o = ctrl_q[`ASP_F_RANGE];
  assign coding_o = ctrl_q[`ASP_F_CODING];
endmodule // asp_ctrl

// File: asp_ctrl_props.sv
// Assertion checker for the converter serial and power control block
`timescale 1ns/1ps
module asp_ctrl_props (
  input wire ref_clk_i,
  input wire nrst_i,
  input wire cs_n_i,
  input wire sclk_i,
  input wire sdo_o,
  input wire sdo_oe_n_o,
  input wire track_o,
  input wire powered_o,
  input wire [1:0] chan_tag_o
);
  // Raw-pin count of serial clock falls in the current frame
  reg [4:0] falls_q;
  // Pins are watched directly, so bounds allow for the synchroniser lag
  always @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i)
      falls_q <= 5'h00;
    else if (cs_n_i)
      falls_q <= 5'h00;
    else if ($fell(sclk_i))
      falls_q <= falls_q + 5'h01;
  end
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!nrst_i);
  chk_drive_zero_first: assert property (
    $fell(cs_n_i) && powered_o |-> ##[1:8] (!sdo_oe_n_o && !sdo_o))
    else $error("output not driven low after select");
  chk_hold_on_select: assert property (
    $fell(cs_n_i) && powered_o |-> ##[1:8] !track_o)
    else $error("no hold after select");
  chk_track_at_14: assert property (
    $fell(sclk_i) && falls_q == 5'h0d && powered_o && !cs_n_i
    |-> ##[1:8] track_o) else $error("no tracking after 14th fall");
  chk_release_at_16: assert property (
    $fell(sclk_i) && falls_q == 5'h0f && !cs_n_i
    |-> ##[1:8] sdo_oe_n_o) else $error("output held after 16th fall");
  chk_abort_release: assert property (
    $rose(cs_n_i) |-> ##[1:8] sdo_oe_n_o)
    else $error("output held after select rise");
  chk_quiet_config: assert property (
    cs_n_i [*8] |-> $stable(chan_tag_o))
    else $error("config moved while deselected");
  chk_sleep_holds: assert property (
    cs_n_i [*8] ##0 !powered_o |-> !track_o)
    else $error("tracking while shut down");
  chk_sleep_at_end: assert property (
    $fell(powered_o) |-> cs_n_i)
    else $error("power down inside a frame");
endmodule // asp_ctrl_props

// File: asp_ctrl_tb.sv
// Self-checking bench for the converter serial and power control block
`timescale 1ns/1ps
`include "asp_defs.vh"
`define CHK(nm, e, g) begin checks = checks + 1; if ((g) !== (e)) begin \
  err_count = err_count + 1; $display("BAD %s exp %h got %h", nm, e, g); end end
module asp_ctrl_tb;
  reg ref_clk_i = 1'b0;
  reg nrst_i = 1'b0;
  reg [`ASP_ADDR_W-1:0] reg_addr_i = 4'h0;
  reg [`ASP_DATA_W-1:0] reg_wdata_i = 16'h0000;
  reg reg_wr_i = 1'b0;
  reg reg_rd_i = 1'b0;
  wire cs_n, sclk, sdi, sdo_o, sdo_oe_n_o, track_o, powered_o, ready_o;
  wire range_o, coding_o;
  wire [1:0] chan_tag_o;
  wire [`ASP_DATA_W-1:0] reg_rdata_o;
  integer err_count = 0;
  integer checks = 0;
  integer cyc = 0; // Cycle count for the hang guard
  reg [15:0] rx;
  reg drv;
  reg [15:0] rd_v;
  asp_ctrl asp_ctrl_inst (.ref_clk_i, .nrst_i, .cs_n_i(cs_n),
    .sclk_i(sclk), .sdi_i(sdi), .sdo_o, .sdo_oe_n_o, .track_o,
    .powered_o, .ready_o, .chan_tag_o, .range_o, .coding_o, .reg_addr_i,
    .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o);
  asp_host_model asp_host_model_inst (.ref_clk_i, .sdo_i(sdo_o),
    .sdo_oe_n_i(sdo_oe_n_o), .cs_n_o(cs_n), .sclk_o(sclk), .sdi_o(sdi));
  initial begin
    forever #12.5 ref_clk_i = ~ref_clk_i;
  end
  // Verdict and end of run
  task end_of_test;
    begin
      if (err_count == 0 && checks > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  // Hang guard: the sequence needs about 1700 cycles
  always @(posedge ref_clk_i) begin
    cyc = cyc + 1;
    if (cyc == 6000) begin
      err_count = err_count + 1;
      end_of_test;
    end
  end
  // Register port write: one strobe cycle
  task wr(input [`ASP_ADDR_W-1:0] a, input [`ASP_DATA_W-1:0] d);
    begin
      @(posedge ref_clk_i);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      @(posedge ref_clk_i);
      reg_wr_i <= 1'b0;
    end
  endtask
  // Register port read: data stands only in the cycle after the strobe
  task rd(input [`ASP_ADDR_W-1:0] a, output [`ASP_DATA_W-1:0] d);
    begin
      @(posedge ref_clk_i);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge ref_clk_i);
      reg_rd_i <= 1'b0;
      @(negedge ref_clk_i);
      d = reg_rdata_o;
    end
  endtask
  initial begin
    repeat (3) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    repeat (4) @(posedge ref_clk_i);
    // Power-up into normal mode with the data line high
    asp_host_model_inst.frame(12'hfff, 5'h10, rx, drv);
    `CHK("powered", 1'b1, powered_o)
    repeat (20) @(posedge ref_clk_i);
    `CHK("ready", 1'b1, ready_o)
    rd(`ASP_REG_CTRL, rd_v);
    `CHK("ctrl", 16'h0fff, rd_v)
    `CHK("range", 1'b1, range_o)
    `CHK("coding", 1'b1, coding_o)
    // Read-only transfer returns the full word, mode untouched
    wr(`ASP_REG_RESULT, 16'h0a5c);
    asp_host_model_inst.frame(12'h000, 5'h10, rx, drv);
    `CHK("word", 16'h3a5c, rx)
    `CHK("driven", 1'b1, drv)
    `CHK("tag", 2'h3, chan_tag_o)
    `CHK("powered", 1'b1, powered_o)
    // Early select rise must not commit the channel-zero write
    asp_host_model_inst.frame(12'h860, 5'h0a, rx, drv);
    `CHK("abort tag", 2'h3, chan_tag_o)
    rd(`ASP_REG_STATUS, rd_v);
    `CHK("abort flag", 1'b1, rd_v[7])
    rd(`ASP_REG_STATUS, rd_v);
    `CHK("abort clear", 1'b0, rd_v[7])
    // Full shutdown, then a wake transfer with the output undriven
    asp_host_model_inst.frame(12'h8c0, 5'h10, rx, drv);
    `CHK("full sd", 1'b0, powered_o)
    `CHK("hold", 1'b0, track_o)
    `CHK("tag", 2'h1, chan_tag_o)
    `CHK("range", 1'b0, range_o)
    `CHK("coding", 1'b0, coding_o)
    asp_host_model_inst.frame(12'h9e0, 5'h10, rx, drv);
    `CHK("undriven", 1'b0, drv)
    `CHK("woken", 1'b1, powered_o)
    // Auto shutdown, entered only once the writing transfer ends
    asp_host_model_inst.frame(12'h820, 5'h10, rx, drv);
    `CHK("auto", 1'b0, powered_o)
    `CHK("tag", 2'h0, chan_tag_o)
    asp_host_model_inst.frame(12'h000, 5'h10, rx, drv);
    `CHK("auto sleep", 1'b0, powered_o)
    `CHK("tag", 2'h0, chan_tag_o)
    // Select fall alone wakes; the short transfer leaves it awake
    asp_host_model_inst.frame(12'h000, 5'h02, rx, drv);
    `CHK("wake", 1'b1, powered_o)
    `CHK("tracking", 1'b1, track_o)
    `CHK("auto ready", 1'b1, ready_o)
    end_of_test;
  end
endmodule // asp_ctrl_tb
bind asp_ctrl asp_ctrl_props asp_ctrl_props_inst (.ref_clk_i, .nrst_i,
  .cs_n_i, .sclk_i, .sdo_o, .sdo_oe_n_o, .track_o, .powered_o, .chan_tag_o);

// File: asp_defs.vh
// Constants for the converter serial transfer and power-mode control block
`ifndef ASP_DEFS_VH
`define ASP_DEFS_VH

// Frame geometry, in serial clock falling edges
`define ASP_FRAME_LEN 5'd16
`define ASP_CTRL_EDGES 5'd12
`define ASP_TRACK_EDGE 5'd14
`define ASP_LAST_LAUNCH 5'd15

// Control register fields (12 bits, write bit first on the serial input)
`define ASP_CTRL_W 12
`define ASP_F_WRITE 11
`define ASP_F_SEQ_HI 10
`define ASP_F_CHAN_HI 8
`define ASP_F_CHAN_LO 7
`define ASP_F_PSEL_HI 6
`define ASP_F_PSEL_LO 5
`define ASP_F_SEQ_LO 4
`define ASP_F_RANGE 2
`define ASP_F_CODING 1
`define ASP_CTRL_RST 12'h000

// Power-select encodings {power_sel_hi, power_sel_lo}
`define ASP_PM_NORMAL 2'b11
`define ASP_PM_FULL_SD 2'b10
`define ASP_PM_AUTO_SD 2'b01

// Register map of the plain register port (word index)
`define ASP_ADDR_W 4
`define ASP_DATA_W 16
`define ASP_REG_CTRL 4'h0
`define ASP_REG_STATUS 4'h1
`define ASP_REG_RESULT 4'h2

// Status register bit positions
`define ASP_S_POWERED 0
`define ASP_S_READY 1
`define ASP_S_TRACK 2
`define ASP_S_FRAME 3
`define ASP_S_PM_LO 4
`define ASP_S_PM_HI 5
`define ASP_S_DRIVE 6
`define ASP_S_ABORT 7

// Timing: system clock rate and wake-up time
`define ASP_CLK_KHZ 40000
`define ASP_WAKE_NS 1000

`endif

// File: asp_host_model.sv
// Host serial port model that frames transfers into the converter block
`timescale 1ns/1ps
module asp_host_model (
  input wire ref_clk_i,
  input wire sdo_i,
  input wire sdo_oe_n_i,
  output reg cs_n_o,
  output reg sclk_o,
  output reg sdi_o
);
  reg busy; // Set while a frame owns the data line
  // Serial clock idles high and stands still between frames
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b1;
    sdi_o = 1'b0;
    busy = 1'b0;
  end
  // Between frames the data line keeps changing, so no stale bit is seen
  always @(posedge ref_clk_i) begin
    if (!busy)
      sdi_o <= ~sdi_o;
  end
  // One transfer: control word write bit first; n falls, fewer aborts
  task frame(input [11:0] w, input [4:0] n, output [15:0] rx,
    output drove);
    integer k;
    begin
      rx = 16'h0000;
      drove = 1'b0;
      // Claim the data line before the edge so the idle toggler stays off
      busy = 1'b1;
      @(posedge ref_clk_i);
      cs_n_o <= 1'b0;
      sdi_o <= w[11];
      repeat (6) @(posedge ref_clk_i);
      for (k = 1; k <= n; k = k + 1) begin
        repeat (4) @(posedge ref_clk_i);
        @(negedge ref_clk_i);
        // A released pad has no pull: the model sees the inverse of the
        // last bit, so an early release shows up in the word
        rx = {rx[14:0], sdo_oe_n_i ? ~rx[0] : sdo_i};
        drove = drove | !sdo_oe_n_i;
        @(posedge ref_clk_i);
        sclk_o <= 1'b0;
        repeat (5) @(posedge ref_clk_i);
        sdi_o <= (k < 12) ? w[11-k] : ~sdi_o;
        sclk_o <= 1'b1;
      end
      repeat (4) @(posedge ref_clk_i);
      cs_n_o <= 1'b1;
      busy = 1'b0;
      // Quiet gap keeps frame starts 5 us apart or more, short ones too
      repeat (30 + 10 * (16 - n)) @(posedge ref_clk_i);
    end
  endtask
endmodule // asp_host_model

// File: asp_pin_sync.v
// Three-stage pin synchroniser with agreement filter and edge pulses
`timescale 1ns/1ps
module asp_pin_sync (
  input wire ref_clk_i,
  input wire rst_n_i,
  input wire [2:0] pin_i,
  output reg [2:0] level_o,
  output wire [2:0] rise_o,
  output wire [2:0] fall_o
);
  // Stage one feeds stage two only; nothing else looks at it
  reg [2:0] s1_q;
  reg [2:0] s2_q;
  reg [2:0] s3_q;
  reg [2:0] level_d;
  reg [2:0] prev_q;
  integer k;

  // Shift chain; idle level high keeps chip select deasserted at reset
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1_q <= 3'h7;
      s2_q <= 3'h7;
      s3_q <= 3'h7;
      level_o <= 3'h7;
      prev_q <= 3'h7;
    end else begin
      s1_q <= pin_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      level_o <= level_d;
      prev_q <= level_o;
    end
  end

  // A change counts only once stages two and three agree
  always @* begin
    level_d = level_o;
    for (k = 0; k < 3; k = k + 1) begin
      if (s2_q[k] == s3_q[k]) begin
        level_d[k] = s3_q[k];
      end
    end
  end

  // One-cycle edge pulses on the filtered level
  assign rise_o = level_o & ~prev_q;
  assign fall_o = ~level_o & prev_q;
endmodule // asp_pin_sync
